// file: design/dsa_defs.vh
`ifndef DSA_DEFS_VH
`define DSA_DEFS_VH
// ----------------------------------------
// Register index (printed offsets), byte address = 4 * index
// ----------------------------------------
`define DSA_IDX_QS_ACTION    16'h605A
`define DSA_IDX_SD_ACTION    16'h605B
`define DSA_IDX_DIS_ACTION   16'h605C
`define DSA_IDX_HALT_ACTION  16'h605D
`define DSA_IDX_SCALE_COUNT  16'h604C
`define DSA_IDX_SCALE_NUM    16'h6100
`define DSA_IDX_SCALE_DEN    16'h6101
`define DSA_IDX_CTRL         16'h6102
`define DSA_IDX_STATUS       16'h6103
`define DSA_IDX_SPEED_IN     16'h6104
`define DSA_IDX_SPEED_RPM    16'h6105
// ----------------------------------------
// Reset values
// ----------------------------------------
`define DSA_RST_QS_ACTION    16'h0002
`define DSA_RST_SD_ACTION    16'h0001
`define DSA_RST_DIS_ACTION   16'h0001
`define DSA_RST_HALT_ACTION  16'h0001
`define DSA_RST_SCALE_COUNT  8'h02
`define DSA_RST_SCALE_NUM    32'h0000_0001
`define DSA_RST_SCALE_DEN    32'h0000_0001
// ----------------------------------------
// Action codes
// ----------------------------------------
`define DSA_ACT_0            16'h0000
`define DSA_ACT_1            16'h0001
`define DSA_ACT_2            16'h0002
`define DSA_ACT_5            16'h0005
`define DSA_ACT_6            16'h0006
// ----------------------------------------
// Field positions and divider step count
// ----------------------------------------
`define DSA_HALT_BIT         8
`define DSA_SCALE_START_BIT  0
`define DSA_DIV_STEPS        64
`endif

// file: design/dsa_divider.v
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Signed serial divider, one quotient bit per clock
// ----------------------------------------
module dsa_divider #(
	parameter W = 64
) (
	// Clock and reset
	input  wire         clk_i,
	input  wire         rst_n_i,
	// Request
	input  wire         start_i,
	input  wire [W-1:0] dividend_i,
	input  wire [W-1:0] divisor_i,
	// Result
	output reg          busy_o,
	output reg          done_o,
	output reg  [W-1:0] quotient_o
);
	reg  [W-1:0] rem_reg;
	reg  [W-1:0] quo_reg;
	reg  [W-1:0] den_reg;
	reg          neg_reg;
	localparam [7:0] CNT_INIT = W;
	reg  [7:0]   cnt_reg;
	wire [W:0]   trial = {rem_reg, quo_reg[W-1]} - {1'b0, den_reg};
	wire [W-1:0] abs_n = dividend_i[W-1] ? (~dividend_i + 1'b1) : dividend_i;
	wire [W-1:0] abs_d = divisor_i[W-1] ? (~divisor_i + 1'b1) : divisor_i;
	wire [W-1:0] q_next = {quo_reg[W-2:0], ~trial[W]};

	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rem_reg    <= {W{1'b0}};
			quo_reg    <= {W{1'b0}};
			den_reg    <= {W{1'b0}};
			neg_reg    <= 1'b0;
			cnt_reg    <= 8'h00;
			busy_o     <= 1'b0;
			done_o     <= 1'b0;
			quotient_o <= {W{1'b0}};
		end else begin
			done_o <= 1'b0;
			if (start_i && !busy_o) begin
				rem_reg <= {W{1'b0}};
				quo_reg <= abs_n;
				den_reg <= abs_d;
				neg_reg <= dividend_i[W-1] ^ divisor_i[W-1];
				cnt_reg <= CNT_INIT;
				busy_o  <= 1'b1;
			end else if (busy_o) begin
				rem_reg <= trial[W] ? {rem_reg[W-2:0], quo_reg[W-1]} : trial[W-1:0];
				quo_reg <= q_next;
				cnt_reg <= cnt_reg - 8'h01;
				if (cnt_reg == 8'h01) begin
					busy_o     <= 1'b0;
					done_o     <= 1'b1;
					quotient_o <= neg_reg ? (~q_next + 1'b1) : q_next;
				end
			end
		end
	end
endmodule // dsa_divider
`default_nettype wire

// file: design/dsa_stop_select.v
// Notes on behaviour
// - Speed in rpm equals internal speed times numerator divided by denominator.
// - Quick-stop code 0: stop at once, then go to Switch on disabled.
// - Quick-stop code 1 slow ramp, 2 quick ramp, then Switch on disabled.
// - Codes 5 or 6: brake, stay in Quick stop, energized, may re-enable.
// - Shutdown code 0 frees motor; code 1 slow ramp then Ready to switch on.
// - Disable code 0 frees motor; code 1 slow ramp then Switched on.
// - Controlword halt bit 8 set runs the configured halt action while the sequencer is idle.
// - Halt code 1 slow ramp, code 2 quick ramp; others reserved.
`timescale 1ns/1ps
`default_nettype none
`include "dsa_defs.vh"
module dsa_stop_select (
	// Clock and reset
	input  wire        CLK_I,
	input  wire        RST_N_I,
	// APB slave
	input  wire        PSEL_I,
	input  wire        PENABLE_I,
	input  wire        PWRITE_I,
	input  wire [31:0] PADDR_I,
	input  wire [31:0] PWDATA_I,
	output wire        PREADY_O,
	output reg  [31:0] PRDATA_O,
	output wire        PSLVERR_O,
	// Power state machine requests
	input  wire        QS_REQ_I,
	input  wire        SHUTDOWN_REQ_I,
	input  wire        DISABLE_REQ_I,
	input  wire        MOTOR_STOPPED_I,
	// Controlword halt bit source
	input  wire [15:0] CONTROLWORD_I,
	// Drive actions
	output reg         STOP_NOW_O,
	output reg         FREEWHEEL_O,
	output reg         RAMP_SLOW_O,
	output reg         RAMP_QUICK_O,
	output reg         HALT_ACTIVE_O,
	// State change requests
	output reg         GO_SWITCH_ON_DISABLED_O,
	output reg         GO_READY_O,
	output reg         GO_SWITCHED_ON_O,
	output reg         STAY_QS_ACTIVE_O,
	// Speed scaling
	input  wire [31:0] SPEED_INTERNAL_I,
	output reg  [31:0] SPEED_RPM_O,
	output reg         SPEED_VALID_O
);
	// ----------------------------------------
	// State codes
	// ----------------------------------------
	localparam [5:0] ST_IDLE = 6'b000001;
	localparam [5:0] ST_QS   = 6'b000010;
	localparam [5:0] ST_QSH  = 6'b000100;
	localparam [5:0] ST_SD   = 6'b001000;
	localparam [5:0] ST_DIS  = 6'b010000;
	localparam [5:0] ST_DONE = 6'b100000;

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	reg  [20:0] sync1_reg;
	reg  [20:0] sync2_reg;
	wire [20:0] raw_in = {CONTROLWORD_I, QS_REQ_I, SHUTDOWN_REQ_I, DISABLE_REQ_I,
		MOTOR_STOPPED_I, 1'b0};
	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			sync1_reg <= 21'h00_0000;
			sync2_reg <= 21'h00_0000;
		end else begin
			sync1_reg <= raw_in;
			sync2_reg <= sync1_reg;
		end
	end
	wire [15:0] ctrl_s    = sync2_reg[20:5];
	wire        qs_s      = sync2_reg[4];
	wire        sd_s      = sync2_reg[3];
	wire        dis_s     = sync2_reg[2];
	wire        stopped_s = sync2_reg[1];

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg  [15:0] qs_action_reg;
	reg  [15:0] sd_action_reg;
	reg  [15:0] dis_action_reg;
	reg  [15:0] halt_action_reg;
	reg  [31:0] scale_num_reg;
	reg  [31:0] scale_den_reg;
	reg         auto_scale_reg;
	reg         scale_go_reg;
	reg  [5:0]  state_reg;
	reg  [5:0]  state_next;

	wire        apb_acc = PSEL_I && PENABLE_I;
	wire        apb_wr  = apb_acc && PWRITE_I;
	wire [15:0] idx     = PADDR_I[17:2];
	wire        aligned = (PADDR_I[1:0] == 2'b00) && (PADDR_I[31:18] == 14'h0000);
	reg         hit;

	always @* begin
		case (idx)
			`DSA_IDX_QS_ACTION, `DSA_IDX_SD_ACTION, `DSA_IDX_DIS_ACTION,
			`DSA_IDX_HALT_ACTION, `DSA_IDX_SCALE_COUNT, `DSA_IDX_SCALE_NUM,
			`DSA_IDX_SCALE_DEN, `DSA_IDX_CTRL, `DSA_IDX_STATUS,
			`DSA_IDX_SPEED_IN, `DSA_IDX_SPEED_RPM: hit = aligned;
			default: hit = 1'b0;
		endcase
	end

	assign PREADY_O  = 1'b1;
	assign PSLVERR_O = apb_acc && !hit;

	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			qs_action_reg   <= `DSA_RST_QS_ACTION;
			sd_action_reg   <= `DSA_RST_SD_ACTION;
			dis_action_reg  <= `DSA_RST_DIS_ACTION;
			halt_action_reg <= `DSA_RST_HALT_ACTION;
			scale_num_reg   <= `DSA_RST_SCALE_NUM;
			scale_den_reg   <= `DSA_RST_SCALE_DEN;
			auto_scale_reg  <= 1'b0;
			scale_go_reg    <= 1'b0;
		end else begin
			scale_go_reg <= 1'b0;
			if (apb_wr && hit) begin
				case (idx)
					`DSA_IDX_QS_ACTION:   qs_action_reg   <= PWDATA_I[15:0];
					`DSA_IDX_SD_ACTION:   sd_action_reg   <= PWDATA_I[15:0];
					`DSA_IDX_DIS_ACTION:  dis_action_reg  <= PWDATA_I[15:0];
					`DSA_IDX_HALT_ACTION: halt_action_reg <= PWDATA_I[15:0];
					`DSA_IDX_SCALE_NUM:   scale_num_reg   <= PWDATA_I;
					`DSA_IDX_SCALE_DEN:   scale_den_reg   <= PWDATA_I;
					`DSA_IDX_CTRL: begin
						auto_scale_reg <= PWDATA_I[1];
						scale_go_reg   <= PWDATA_I[`DSA_SCALE_START_BIT];
					end
					default: ;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Speed scaling
	// ----------------------------------------
	reg  [63:0] product_reg;
	reg         prod_ok_reg;
	wire        div_busy;
	wire        div_done;
	wire [63:0] quotient;
	wire        trig = scale_go_reg || (auto_scale_reg && !div_busy && !prod_ok_reg);

	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			product_reg <= 64'h0000_0000_0000_0000;
			prod_ok_reg <= 1'b0;
		end else begin
			prod_ok_reg <= trig && !div_busy;
			if (trig && !div_busy) begin
				product_reg <= $signed(SPEED_INTERNAL_I) * $signed(scale_num_reg);
			end
		end
	end

	dsa_divider #(
		.W(64)
	) u_div (
		.clk_i      (CLK_I),
		.rst_n_i    (RST_N_I),
		.start_i    (prod_ok_reg),
		.dividend_i (product_reg),
		.divisor_i  ({{32{scale_den_reg[31]}}, scale_den_reg}),
		.busy_o     (div_busy),
		.done_o     (div_done),
		.quotient_o (quotient)
	);

	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			SPEED_RPM_O   <= 32'h0000_0000;
			SPEED_VALID_O <= 1'b0;
		end else if (div_done) begin
			SPEED_RPM_O   <= quotient[31:0];
			SPEED_VALID_O <= 1'b1;
		end
	end

	// ----------------------------------------
	// Stop action sequencer
	// ----------------------------------------
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (qs_s)
					state_next = ST_QS;
				else if (sd_s)
					state_next = ST_SD;
				else if (dis_s)
					state_next = ST_DIS;
			end
			ST_QS: begin
				if (qs_action_reg == `DSA_ACT_0)
					state_next = ST_DONE;
				else if (stopped_s && (qs_action_reg == `DSA_ACT_5 ||
					qs_action_reg == `DSA_ACT_6))
					state_next = ST_QSH;
				else if (stopped_s)
					state_next = ST_DONE;
			end
			ST_QSH: begin
				if (!qs_s)
					state_next = ST_IDLE;
			end
			ST_SD: begin
				if (sd_action_reg == `DSA_ACT_0 || stopped_s)
					state_next = ST_DONE;
			end
			ST_DIS: begin
				if (dis_action_reg == `DSA_ACT_0 || stopped_s)
					state_next = ST_DONE;
			end
			ST_DONE: begin
				if (!qs_s && !sd_s && !dis_s)
					state_next = ST_IDLE;
			end
			default: state_next = ST_IDLE;
		endcase
	end

	reg [5:0] from_reg;
	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			state_reg <= ST_IDLE;
			from_reg  <= ST_IDLE;
		end else begin
			state_reg <= state_next;
			if (state_reg != ST_DONE)
				from_reg <= state_reg;
		end
	end

	// ----------------------------------------
	// Action outputs
	// ----------------------------------------
	wire halt_on = ctrl_s[`DSA_HALT_BIT] && (state_reg == ST_IDLE);
	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			STOP_NOW_O              <= 1'b0;
			FREEWHEEL_O             <= 1'b0;
			RAMP_SLOW_O             <= 1'b0;
			RAMP_QUICK_O            <= 1'b0;
			HALT_ACTIVE_O           <= 1'b0;
			GO_SWITCH_ON_DISABLED_O <= 1'b0;
			GO_READY_O              <= 1'b0;
			GO_SWITCHED_ON_O        <= 1'b0;
			STAY_QS_ACTIVE_O        <= 1'b0;
		end else begin
			STOP_NOW_O   <= (state_reg == ST_QS) && (qs_action_reg == `DSA_ACT_0);
			FREEWHEEL_O  <= ((state_reg == ST_SD) && (sd_action_reg == `DSA_ACT_0)) ||
				((state_reg == ST_DIS) && (dis_action_reg == `DSA_ACT_0));
			RAMP_SLOW_O  <= ((state_reg == ST_QS) && (qs_action_reg == `DSA_ACT_1 ||
				qs_action_reg == `DSA_ACT_5)) ||
				((state_reg == ST_SD) && (sd_action_reg == `DSA_ACT_1)) ||
				((state_reg == ST_DIS) && (dis_action_reg == `DSA_ACT_1)) ||
				(halt_on && halt_action_reg == `DSA_ACT_1);
			RAMP_QUICK_O <= ((state_reg == ST_QS) && (qs_action_reg == `DSA_ACT_2 ||
				qs_action_reg == `DSA_ACT_6)) ||
				(halt_on && halt_action_reg == `DSA_ACT_2);
			HALT_ACTIVE_O <= halt_on;
			GO_SWITCH_ON_DISABLED_O <= (state_reg == ST_DONE) && (from_reg == ST_QS);
			GO_READY_O       <= (state_reg == ST_DONE) && (from_reg == ST_SD);
			GO_SWITCHED_ON_O <= (state_reg == ST_DONE) && (from_reg == ST_DIS);
			STAY_QS_ACTIVE_O <= (state_reg == ST_QSH);
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			PRDATA_O <= 32'h0000_0000;
		end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
			case (idx)
				`DSA_IDX_QS_ACTION:   PRDATA_O <= {16'h0000, qs_action_reg};
				`DSA_IDX_SD_ACTION:   PRDATA_O <= {16'h0000, sd_action_reg};
				`DSA_IDX_DIS_ACTION:  PRDATA_O <= {16'h0000, dis_action_reg};
				`DSA_IDX_HALT_ACTION: PRDATA_O <= {16'h0000, halt_action_reg};
				`DSA_IDX_SCALE_COUNT: PRDATA_O <= {24'h00_0000, `DSA_RST_SCALE_COUNT};
				`DSA_IDX_SCALE_NUM:   PRDATA_O <= scale_num_reg;
				`DSA_IDX_SCALE_DEN:   PRDATA_O <= scale_den_reg;
				`DSA_IDX_CTRL:        PRDATA_O <= {30'h0000_0000, auto_scale_reg, 1'b0};
				`DSA_IDX_STATUS:      PRDATA_O <= {24'h00_0000, div_busy, halt_on, state_reg};
				`DSA_IDX_SPEED_IN:    PRDATA_O <= SPEED_INTERNAL_I;
				`DSA_IDX_SPEED_RPM:   PRDATA_O <= SPEED_RPM_O;
				default:              PRDATA_O <= 32'h0000_0000;
			endcase
		end
	end
endmodule // dsa_stop_select
`default_nettype wire

// file: bench/dsa_stop_select_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module dsa_checker (
	// Clock, reset, requests
	input wire logic        CLK_I,
	input wire logic        RST_N_I,
	input wire logic        QS_REQ_I,
	input wire logic        DISABLE_REQ_I,
	input wire logic [15:0] CONTROLWORD_I,
	// Actions and state changes
	input wire logic        STOP_NOW_O,
	input wire logic        FREEWHEEL_O,
	input wire logic        RAMP_SLOW_O,
	input wire logic        RAMP_QUICK_O,
	input wire logic        HALT_ACTIVE_O,
	input wire logic        GO_SWITCH_ON_DISABLED_O,
	input wire logic        GO_READY_O,
	input wire logic        GO_SWITCHED_ON_O,
	input wire logic        STAY_QS_ACTIVE_O,
	input wire logic        SPEED_VALID_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);

	AST_STOP_EXCL: assert property (STOP_NOW_O |-> !RAMP_SLOW_O && !RAMP_QUICK_O)
		else $error("stop together with ramp");
	AST_GO_SOD: assert property ($rose(GO_SWITCH_ON_DISABLED_O) |-> $past(QS_REQ_I, 3))
		else $error("disabled state without quick stop");
	AST_RAMP_EXCL: assert property (RAMP_SLOW_O |-> !RAMP_QUICK_O)
		else $error("both ramps on");
	AST_STAY_QS: assert property (STAY_QS_ACTIVE_O |-> !GO_SWITCH_ON_DISABLED_O && !FREEWHEEL_O)
		else $error("quick stop hold left");
	AST_GO_ONEHOT: assert property (GO_READY_O |-> !GO_SWITCHED_ON_O && !GO_SWITCH_ON_DISABLED_O)
		else $error("two state changes");
	AST_GO_SWON: assert property ($rose(GO_SWITCHED_ON_O) |-> $past(DISABLE_REQ_I, 3))
		else $error("switched on without disable");
	AST_HALT_SRC: assert property (HALT_ACTIVE_O |-> $past(CONTROLWORD_I[8], 2) ||
		$past(CONTROLWORD_I[8], 3) || $past(CONTROLWORD_I[8], 4))
		else $error("halt without halt bit");
	AST_HALT_ON: assert property (CONTROLWORD_I[8] [*5] |-> HALT_ACTIVE_O)
		else $error("halt bit ignored");
	AST_HALT_RAMP: assert property (HALT_ACTIVE_O |-> RAMP_SLOW_O ^ RAMP_QUICK_O)
		else $error("halt without one ramp");
	AST_SPEED_HOLD: assert property (SPEED_VALID_O |=> SPEED_VALID_O)
		else $error("speed valid dropped");
endmodule // dsa_checker

bind dsa_stop_select dsa_checker u_chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .QS_REQ_I(QS_REQ_I),
	.DISABLE_REQ_I(DISABLE_REQ_I), .CONTROLWORD_I(CONTROLWORD_I), .STOP_NOW_O(STOP_NOW_O),
	.FREEWHEEL_O(FREEWHEEL_O), .RAMP_SLOW_O(RAMP_SLOW_O), .RAMP_QUICK_O(RAMP_QUICK_O),
	.HALT_ACTIVE_O(HALT_ACTIVE_O), .GO_SWITCH_ON_DISABLED_O(GO_SWITCH_ON_DISABLED_O),
	.GO_READY_O(GO_READY_O), .GO_SWITCHED_ON_O(GO_SWITCHED_ON_O),
	.STAY_QS_ACTIVE_O(STAY_QS_ACTIVE_O), .SPEED_VALID_O(SPEED_VALID_O));
`default_nettype wire

// file: bench/dsa_motor_model.sv
`timescale 1ns/1ps
`default_nettype none
module dsa_motor_model (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic brake_i,
	input  wire logic slow_i,
	output var  logic stopped_o
);
	logic [5:0] cnt_reg;

	// Standstill some cycles after braking starts
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_reg   <= 6'h0;
			stopped_o <= 1'b0;
		end else if (!brake_i) begin
			cnt_reg   <= 6'h0;
			stopped_o <= 1'b0;
		end else if (cnt_reg == (slow_i ? 6'h28 : 6'h2)) begin
			stopped_o <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 6'h1;
		end
	end
endmodule // dsa_motor_model
`default_nettype wire

// file: bench/dsa_stop_select_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "dsa_defs.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
	$display("wrong value at %0t: got %h want %h", $time, g, e); end end
`define WAIT(c) repeat (300) if (!(c)) @(posedge clk);
module dsa_stop_select_bench;
	logic        clk, rst_n, psel, penable, pwrite, qs, sd, dis, slow, err;
	logic [31:0] paddr, pwdata, spd, rdata, lfsr, a, n, d, tmp;
	logic [15:0] cw;
	wire  logic  pready, pslverr, stopped, halt_on, valid;
	wire  logic [3:0]  acts, gos;
	wire  logic [31:0] prdata, rpm;
	int          failures = 0, checked = 0, cycles = 0;

	dsa_stop_select dut (.CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
		.PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PREADY_O(pready),
		.PRDATA_O(prdata), .PSLVERR_O(pslverr), .QS_REQ_I(qs), .SHUTDOWN_REQ_I(sd),
		.DISABLE_REQ_I(dis), .MOTOR_STOPPED_I(stopped), .CONTROLWORD_I(cw),
		.STOP_NOW_O(acts[3]), .FREEWHEEL_O(acts[2]), .RAMP_SLOW_O(acts[1]),
		.RAMP_QUICK_O(acts[0]), .HALT_ACTIVE_O(halt_on), .GO_SWITCH_ON_DISABLED_O(gos[3]),
		.GO_READY_O(gos[2]), .GO_SWITCHED_ON_O(gos[1]), .STAY_QS_ACTIVE_O(gos[0]),
		.SPEED_INTERNAL_I(spd), .SPEED_RPM_O(rpm), .SPEED_VALID_O(valid));
	dsa_motor_model motor (.clk_i(clk), .rst_n_i(rst_n), .brake_i(|{acts, gos}),
		.slow_i(slow), .stopped_o(stopped));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 8000) begin
			failures++;
			conclude();
		end
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction

	function automatic logic [31:0] rpm_of(input logic [31:0] x, y, z);
		longint p;
		p = longint'($signed(x)) * longint'($signed(y));
		return 32'(p / longint'($signed(z)));
	endfunction

	task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {14'h0000, idx, 2'h0};
		pwdata <= wd;
		@(posedge clk) penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && cycles < 8000) @(posedge clk);
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic seq(input logic [15:0] idx, code, input logic [2:0] req,
		input logic [3:0] ea, eg);
		apb(1'b1, idx, {16'h0000, code});
		tmp = rnd();
		slow <= tmp[0];
		{qs, sd, dis} <= req;
		`WAIT(|acts)
		`CHK(acts, ea)
		`WAIT(|gos)
		`CHK(gos, eg)
		{qs, sd, dis} <= 3'h0;
		`WAIT(!(|gos))
	endtask

	task automatic conclude();
		$display("failures %0d checked %0d", failures, checked);
		if (failures == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{psel, penable, pwrite, qs, sd, dis, slow, rst_n} = 8'h00;
		{paddr, pwdata, spd} = 96'h0;
		cw = 16'h0000;
		lfsr = 32'h29f0_45be;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		apb(1'b0, `DSA_IDX_QS_ACTION, 0); `CHK(rdata, 32'h0000_0002)
		apb(1'b0, `DSA_IDX_SD_ACTION, 0); `CHK(rdata, 32'h0000_0001)
		apb(1'b0, `DSA_IDX_DIS_ACTION, 0); `CHK(rdata, 32'h0000_0001)
		apb(1'b0, `DSA_IDX_HALT_ACTION, 0); `CHK(rdata, 32'h0000_0001)
		apb(1'b1, `DSA_IDX_SCALE_COUNT, 32'hffff_ffff);
		apb(1'b0, `DSA_IDX_SCALE_COUNT, 0); `CHK(rdata, 32'h0000_0002)
		apb(1'b0, 16'h7000, 0); `CHK(err, 1'b1)
		seq(`DSA_IDX_QS_ACTION, 16'h0000, 3'h4, 4'h8, 4'h8);
		seq(`DSA_IDX_QS_ACTION, 16'h0001, 3'h4, 4'h2, 4'h8);
		seq(`DSA_IDX_QS_ACTION, 16'h0002, 3'h4, 4'h1, 4'h8);
		seq(`DSA_IDX_QS_ACTION, 16'h0005, 3'h4, 4'h2, 4'h1);
		seq(`DSA_IDX_QS_ACTION, 16'h0006, 3'h7, 4'h1, 4'h1);
		seq(`DSA_IDX_SD_ACTION, 16'h0000, 3'h2, 4'h4, 4'h4);
		seq(`DSA_IDX_SD_ACTION, 16'h0001, 3'h3, 4'h2, 4'h4);
		seq(`DSA_IDX_DIS_ACTION, 16'h0000, 3'h1, 4'h4, 4'h2);
		seq(`DSA_IDX_DIS_ACTION, 16'h0001, 3'h1, 4'h2, 4'h2);
		for (int c = 1; c < 3; c++) begin
			apb(1'b1, `DSA_IDX_HALT_ACTION, 32'(c));
			tmp = rnd();
			cw <= tmp[15:0] | 16'h0100;
			`WAIT(halt_on)
			`CHK({halt_on, acts}, (c == 1) ? 5'h12 : 5'h11)
			cw <= tmp[15:0] & 16'hfeff;
			`WAIT(!halt_on)
			`CHK(acts, 4'h0)
		end
		for (int i = 0; i < 8; i++) begin
			a = rnd();
			n = rnd();
			d = rnd();
			a = {{12{a[19]}}, a[19:0]};
			n = (i == 0) ? 32'h0000_0001 : {{16{n[15]}}, n[15:0]};
			d = (i == 0) ? 32'h0000_0001 : {{24{d[7]}}, d[7:1], 1'h1};
			spd <= a;
			if (i > 0) apb(1'b1, `DSA_IDX_SCALE_NUM, n);
			if (i > 0) apb(1'b1, `DSA_IDX_SCALE_DEN, d);
			apb(1'b1, `DSA_IDX_CTRL, 32'h0000_0001);
			repeat (3) @(posedge clk);
			repeat (60) begin
				apb(1'b0, `DSA_IDX_STATUS, 0);
				if (rdata[7] === 1'b0) break;
			end
			`CHK(rpm, rpm_of(a, n, d))
			apb(1'b0, `DSA_IDX_SPEED_RPM, 0); `CHK(rdata, rpm_of(a, n, d))
		end
		`CHK(valid, 1'b1)
		conclude();
	end
endmodule // dsa_stop_select_bench
`default_nettype wire
